// ==== rtl/becsr_params.svh ====
`ifndef BECSR_PARAMS_SVH
`define BECSR_PARAMS_SVH
// Contract
// - CEC source bit picks internal clock (0) or 25MHz oscillator (1) for 32.768kHz.
// - CEC clock is produced only while the CEC clock enable bit is set.
// - Wipe takes effect only with reload; wipe bit self-clears when done.
// - Writing 1 to reload refills SRAM from EEPROM; bit clears on completion.
// - Access-block bit is caught from mode strap 0; it blocks DDC SRAM access.
// - Source power status bit follows the source power pin.
// - Receiver interrupt status bit reads 1 while receiver interrupt is pending.
// - Initialization done asserts only after configuration complete.
// - Remote-loaded bit sets after SRAM filled from remote EEPROM.
// - Config checksum bit is 1 when last 128 EEPROM bytes sum to zero.
// - Display-ID checksum bit is 1 when first 256 EEPROM bytes sum to zero.
// - Slave address field 7:1, default 0x50, selects DDC slave; bit 0 is R/W.
// - Write-protect bit 1 refuses DDC SRAM writes; 0 accepts them.
// - Data hold field 6:4 sets DDC data hold in 40ns steps.
// - Glitch filter field 3:0, default 0x0E, rejects glitches in 5ns steps.
// - Output delay field 1:0 gives 240/280/320/360ns data delay.
// - Offsets 0x4D and 0x4E hold indirect data bytes 2 and 3.
// - Indirect read completion loads the data bytes.

// ==========================================================
// Register offsets
`define BE_ADDR_DATA2 8'h4D
`define BE_ADDR_DATA3 8'h4E
`define BE_ADDR_CTL 8'h4F
`define BE_ADDR_STS 8'h50
`define BE_ADDR_ID 8'h51
`define BE_ADDR_CFG0 8'h52
`define BE_ADDR_CFG1 8'h53
// ==========================================================
// Field positions
`define BE_CTL_SRC 4
`define BE_CTL_EN 3
`define BE_CTL_WIPE 2
`define BE_CTL_RELOAD 1
`define BE_CTL_BLOCK 0
// ==========================================================
// Reset values
`define BE_DATA_RESET 8'h00
`define BE_STS_RESET 8'h03
`define BE_ID_ADDR_RESET 7'h50
`define BE_HOLD_RESET 3'h1
`define BE_FLT_RESET 4'hE
`define BE_DLY_RESET 2'h0
// ==========================================================
// Timing
`define BE_CLK_HZ 100000000
`define BE_EXT_HZ 25000000
`define BE_CEC_HZ 32768
`define BE_CLK_NS 10
`define BE_HOLD_STEP_NS 40
`define BE_FLT_STEP_NS 5
`define BE_DLY_BASE_NS 240
`define BE_DLY_STEP_NS 40
`define BE_CEC_INC(f) 24'(((64'(`BE_CEC_HZ) << 24) + 64'(f) / 2) / 64'(f))
`define BE_CFG_BYTES 128
`define BE_EDID_BYTES 256
`endif

// ==== rtl/becsr_pkg.sv ====
package becsr_pkg;
   // Boot, config, init, idle and display-ID load along a Gray path
   typedef enum logic [2:0]
   {
      ST_BOOT = 3'b000,
      ST_CFG = 3'b001,
      ST_INIT = 3'b011,
      ST_IDLE = 3'b010,
      ST_EDID = 3'b110
   } becsr_state_type;
endpackage : becsr_pkg

// ==== rtl/becsr_regs.sv ====
`timescale 1ns/100ps
`include "becsr_params.svh"

module becsr_regs
   import becsr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Pins and straps
   input wire logic mode_strap0_i,
   input wire logic source_power_pin_i,
   input wire logic ext_osc_i,
   // Receive controller
   input wire logic rx_int_pending_i,
   output logic cec_clk_o,
   // Indirect data path
   input wire logic apb_rd_done_i,
   input wire logic [15:0] apb_rd_data_i,
   output logic [15:0] indirect_data_o,
   // EEPROM byte stream
   output logic eep_req_o,
   input wire logic eep_valid_i,
   input wire logic [7:0] eep_byte_i,
   input wire logic eep_remote_i,
   input wire logic init_ack_i,
   // Display-ID SRAM write port
   output logic sram_we_o,
   output logic [7:0] sram_addr_o,
   output logic [7:0] sram_wdata_o,
   // DDC slave settings
   input wire logic [7:0] ddc_addr_byte_i,
   output logic ddc_addr_hit_o,
   output logic ddc_write_ok_o,
   output logic ddc_block_o,
   output logic [4:0] ddc_hold_cyc_o,
   output logic [2:0] ddc_filter_cyc_o,
   output logic [5:0] ddc_delay_cyc_o
);
   localparam logic [23:0] CEC_INC_INT = `BE_CEC_INC(`BE_CLK_HZ);
   localparam logic [23:0] CEC_INC_EXT = `BE_CEC_INC(`BE_EXT_HZ);
   localparam logic [8:0] CFG_LAST = 9'(`BE_CFG_BYTES - 1);
   localparam logic [8:0] EDID_LAST = 9'(`BE_EDID_BYTES - 1);
   localparam logic [7:0] STS_RESET = `BE_STS_RESET;
   becsr_state_type state_r;
   logic [7:0] data2_r, data3_r;
   logic cec_src_r, cec_en_r, wipe_r, reload_r, block_r;
   logic cfg_done_r, init_done_r, remote_r, cfg_ok_r, id_ok_r;
   logic [6:0] slave_r;
   logic rdonly_r, ext_osc_r;
   logic [2:0] hold_r;
   logic [3:0] flt_r;
   logic [1:0] dly_r;
   logic [23:0] cec_acc_r;
   logic [8:0] cnt_r;
   logic [7:0] sum_r, sum_nxt;
   logic byte_take, wipe_step, last_byte;
   function automatic logic reg_hit(input logic [7:0] addr);
      reg_hit = reg_wr_i && (reg_addr_i == addr);
   endfunction : reg_hit
   // ==========================================================
   // Indirect data bytes
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         data2_r <= `BE_DATA_RESET;
         data3_r <= `BE_DATA_RESET;
      end
      else if (apb_rd_done_i)
      begin
         data2_r <= apb_rd_data_i[7:0];
         data3_r <= apb_rd_data_i[15:8];
      end
      else
      begin
         if (reg_hit(`BE_ADDR_DATA2))
            data2_r <= reg_wdata_i;
         if (reg_hit(`BE_ADDR_DATA3))
            data3_r <= reg_wdata_i;
      end
   end
   assign indirect_data_o = {data3_r, data2_r};
   // ==========================================================
   // Bridge control
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cec_src_r <= 1'b0;
         cec_en_r <= 1'b0;
         wipe_r <= 1'b0;
         reload_r <= 1'b0;
      end
      else if (reg_hit(`BE_ADDR_CTL))
      begin
         cec_src_r <= reg_wdata_i[`BE_CTL_SRC];
         cec_en_r <= reg_wdata_i[`BE_CTL_EN];
         // A new request wins over completion in the same cycle
         wipe_r <= reg_wdata_i[`BE_CTL_WIPE] | (wipe_r & ~last_byte & state_r == ST_EDID);
         reload_r <= reg_wdata_i[`BE_CTL_RELOAD] | (reload_r & ~last_byte);
      end
      else if (state_r == ST_EDID && last_byte)
      begin
         wipe_r <= 1'b0;
         reload_r <= 1'b0;
      end
   end
   // Strap is caught by the clock after reset release
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         block_r <= 1'b0;
      else if (state_r == ST_BOOT)
         block_r <= mode_strap0_i;
   end
   // ==========================================================
   // Configuration, initialization and display-ID load sequence
   assign eep_req_o = (state_r == ST_CFG) || (state_r == ST_EDID && !wipe_r);
   assign byte_take = eep_req_o && eep_valid_i;
   assign wipe_step = (state_r == ST_EDID) && wipe_r && reload_r;
   assign sum_nxt = sum_r + eep_byte_i;
   assign last_byte = (byte_take || wipe_step) &&
      (cnt_r == ((state_r == ST_CFG) ? CFG_LAST : EDID_LAST));
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_r <= ST_BOOT;
      else
      begin
         case (state_r)
            ST_BOOT: state_r <= ST_CFG;
            ST_CFG: if (last_byte) state_r <= ST_INIT;
            ST_INIT: if (init_ack_i) state_r <= ST_IDLE;
            ST_IDLE: if (reload_r) state_r <= ST_EDID;
            ST_EDID: if (last_byte) state_r <= ST_IDLE;
            default: state_r <= ST_BOOT;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= 9'h000;
         sum_r <= 8'h00;
      end
      else if (last_byte || state_r == ST_IDLE)
      begin
         cnt_r <= 9'h000;
         sum_r <= 8'h00;
      end
      else if (byte_take || wipe_step)
      begin
         cnt_r <= cnt_r + 9'h001;
         sum_r <= byte_take ? sum_nxt : sum_r;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_done_r <= 1'b0;
         init_done_r <= 1'b0;
         cfg_ok_r <= STS_RESET[1];
         id_ok_r <= STS_RESET[0];
         remote_r <= 1'b0;
      end
      else
      begin
         if (state_r == ST_CFG && last_byte)
         begin
            cfg_done_r <= 1'b1;
            cfg_ok_r <= (sum_nxt == 8'h00);
         end
         if (state_r == ST_INIT && init_ack_i && cfg_done_r)
            init_done_r <= 1'b1;
         if (state_r == ST_EDID && last_byte && byte_take)
         begin
            id_ok_r <= (sum_nxt == 8'h00);
            remote_r <= eep_remote_i;
         end
      end
   end

   // SRAM writes: EEPROM bytes, or zeros when wiping
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sram_we_o <= 1'b0;
         sram_addr_o <= 8'h00;
         sram_wdata_o <= 8'h00;
      end
      else
      begin
         sram_we_o <= (state_r == ST_EDID) && (byte_take || wipe_step);
         sram_addr_o <= cnt_r[7:0];
         sram_wdata_o <= wipe_step ? 8'h00 : eep_byte_i;
      end
   end

   // ==========================================================
   // CEC clock generator
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cec_acc_r <= 24'h000000;
         ext_osc_r <= 1'b0;
      end
      else
      begin
         ext_osc_r <= ext_osc_i;
         if (!cec_en_r)
            cec_acc_r <= 24'h000000;
         else if (!cec_src_r)
            cec_acc_r <= cec_acc_r + CEC_INC_INT;
         else if (ext_osc_i && !ext_osc_r)
            cec_acc_r <= cec_acc_r + CEC_INC_EXT;
      end
   end
   assign cec_clk_o = cec_acc_r[23];
   // ==========================================================
   // DDC slave configuration
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         slave_r <= `BE_ID_ADDR_RESET;
         rdonly_r <= 1'b0;
         hold_r <= `BE_HOLD_RESET;
         flt_r <= `BE_FLT_RESET;
         dly_r <= `BE_DLY_RESET;
      end
      else
      begin
         if (reg_hit(`BE_ADDR_ID))
         begin
            slave_r <= reg_wdata_i[7:1];
            rdonly_r <= reg_wdata_i[0];
         end
         if (reg_hit(`BE_ADDR_CFG0))
         begin
            hold_r <= reg_wdata_i[6:4];
            flt_r <= reg_wdata_i[3:0];
         end
         if (reg_hit(`BE_ADDR_CFG1))
            dly_r <= reg_wdata_i[1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ddc_hold_cyc_o <= 5'h00;
         ddc_filter_cyc_o <= 3'h0;
         ddc_delay_cyc_o <= 6'h00;
      end
      else
      begin
         ddc_hold_cyc_o <= 5'(hold_r * (`BE_HOLD_STEP_NS / `BE_CLK_NS));
         ddc_filter_cyc_o <= 3'((flt_r * `BE_FLT_STEP_NS) / `BE_CLK_NS);
         ddc_delay_cyc_o <= 6'((`BE_DLY_BASE_NS + dly_r * `BE_DLY_STEP_NS)
            / `BE_CLK_NS);
      end
   end
   assign ddc_block_o = block_r;
   assign ddc_addr_hit_o = !block_r && (ddc_addr_byte_i[7:1] == slave_r);
   assign ddc_write_ok_o = ddc_addr_hit_o && !ddc_addr_byte_i[0] && !rdonly_r;
   // ==========================================================
   // Read data; reserved bits read zero
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            `BE_ADDR_DATA2: reg_rdata_o <= data2_r;
            `BE_ADDR_DATA3: reg_rdata_o <= data3_r;
            `BE_ADDR_CTL: reg_rdata_o <= {3'h0, cec_src_r, cec_en_r, wipe_r,
               reload_r, block_r};
            `BE_ADDR_STS: reg_rdata_o <= {source_power_pin_i, rx_int_pending_i,
               1'b0, init_done_r, remote_r, cfg_done_r, cfg_ok_r, id_ok_r};
            `BE_ADDR_ID: reg_rdata_o <= {slave_r, rdonly_r};
            `BE_ADDR_CFG0: reg_rdata_o <= {1'b0, hold_r, flt_r};
            `BE_ADDR_CFG1: reg_rdata_o <= {6'h00, dly_r};
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end
   // ==========================================================
   // Assertions
   sequence s_reload_req;
      state_r == ST_IDLE && reload_r;
   endsequence
   sequence s_edid_run;
      state_r == ST_EDID;
   endsequence
   strap_catch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_r == ST_BOOT |=> block_r == $past(mode_strap0_i)) else $error("strap not captured");
   cec_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !cec_en_r |=> !cec_clk_o) else $error("cec clock runs while disabled");
   init_order_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      init_done_r |-> cfg_done_r) else $error("init done before config done");
   reload_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_reload_req |=> s_edid_run) else $error("reload did not start");
   reload_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(reload_r) |-> $past(state_r) == ST_EDID && $past(last_byte))
      else $error("reload cleared early");
   wipe_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      sram_we_o && $past(wipe_r) |-> sram_wdata_o == 8'h00) else $error("wipe wrote nonzero");
   cfg_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(cfg_done_r) |-> $past(cnt_r) == CFG_LAST) else $error("config checksum length wrong");
   write_prot_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      rdonly_r || block_r |-> !ddc_write_ok_o) else $error("protected write allowed");
   data_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      apb_rd_done_i |=> indirect_data_o == $past(apb_rd_data_i))
      else $error("indirect data not loaded");
   delay_cfg_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_hit(`BE_ADDR_CFG1) |=> ##1
      ddc_delay_cyc_o == 6'd24 + 6'({$past(reg_wdata_i[1:0], 2), 2'b00}))
      else $error("output delay count wrong");
   pwr_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i == `BE_ADDR_STS |=> reg_rdata_o[7] == $past(source_power_pin_i))
      else $error("power status wrong");
endmodule : becsr_regs

// ==== verif/becsr_eep_model.sv ====
`timescale 1ns/100ps

module becsr_eep_model
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Byte stream
   input wire logic eep_req_i,
   output logic eep_valid_o,
   output logic [7:0] eep_byte_o,
   // Image length, checksum fault, stalls
   input wire logic [8:0] len_i,
   input wire logic bad_i,
   input wire logic slow_i
);
   logic [8:0] cnt_r;
   logic [7:0] sum_r;
   logic [7:0] last_r;
   logic gap_r;
   logic tail;

   assign tail = cnt_r == len_i - 9'h001;
   assign eep_valid_o = eep_req_i & ~gap_r;
   // Idle bus shows the inverse of the last byte
   assign eep_byte_o = !eep_valid_o ? ~last_r :
      tail ? 8'h00 - sum_r + {7'h00, bad_i} : cnt_r[7:0] * 8'h25 + 8'h05;

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         cnt_r <= 9'h000;
         sum_r <= 8'h00;
         last_r <= 8'h00;
         gap_r <= 1'b0;
      end
      else
      begin
         gap_r <= slow_i & ~gap_r;
         if (eep_valid_o)
         begin
            last_r <= eep_byte_o;
            sum_r <= tail ? 8'h00 : sum_r + eep_byte_o;
            cnt_r <= tail ? 9'h000 : cnt_r + 9'h001;
         end
      end
endmodule : becsr_eep_model

// ==== verif/bridge_edid_control_status_regs_tb.sv ====
`timescale 1ns/100ps

module bridge_edid_control_status_regs_tb;
   import becsr_pkg::*;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, ext_osc_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, ddc_addr_byte_i = 8'h00;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, mode_strap0_i = 1'b0;
   logic source_power_pin_i = 1'b0, rx_int_pending_i = 1'b0, apb_rd_done_i = 1'b0;
   logic [15:0] apb_rd_data_i = 16'h0000;
   logic eep_remote_i = 1'b0, init_ack_i = 1'b0, bad = 1'b0, slow = 1'b1;
   logic [8:0] len = 9'h080;
   logic [7:0] reg_rdata_o, sram_addr_o, sram_wdata_o, eep_byte_i;
   logic [15:0] indirect_data_o;
   logic cec_clk_o, eep_req_o, eep_valid_i, sram_we_o, ddc_addr_hit_o, ddc_write_ok_o;
   logic ddc_block_o, pend = 1'b0, wiping = 1'b0;
   logic [4:0] ddc_hold_cyc_o, st_lo;
   logic [2:0] ddc_filter_cyc_o;
   logic [5:0] ddc_delay_cyc_o;
   logic [7:0] exp_q[$];
   logic [7:0] sw_a[7] = '{8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h53};
   logic [7:0] sw_m[7] = '{8'hFF, 8'hFF, 8'h18, 8'h00, 8'hFF, 8'h7F, 8'h03};
   int bad_count = 0, checked = 0, cyc = 0, we_cnt = 0, seed;

   always #5 clk_sys_i = ~clk_sys_i;
   always #20 ext_osc_i = ~ext_osc_i;

   becsr_regs i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .mode_strap0_i(mode_strap0_i),
      .source_power_pin_i(source_power_pin_i), .ext_osc_i(ext_osc_i),
      .rx_int_pending_i(rx_int_pending_i), .cec_clk_o(cec_clk_o),
      .apb_rd_done_i(apb_rd_done_i), .apb_rd_data_i(apb_rd_data_i),
      .indirect_data_o(indirect_data_o), .eep_req_o(eep_req_o), .eep_valid_i(eep_valid_i),
      .eep_byte_i(eep_byte_i), .eep_remote_i(eep_remote_i), .init_ack_i(init_ack_i),
      .sram_we_o(sram_we_o), .sram_addr_o(sram_addr_o), .sram_wdata_o(sram_wdata_o),
      .ddc_addr_byte_i(ddc_addr_byte_i), .ddc_addr_hit_o(ddc_addr_hit_o),
      .ddc_write_ok_o(ddc_write_ok_o), .ddc_block_o(ddc_block_o),
      .ddc_hold_cyc_o(ddc_hold_cyc_o), .ddc_filter_cyc_o(ddc_filter_cyc_o),
      .ddc_delay_cyc_o(ddc_delay_cyc_o));

   becsr_eep_model i_eep (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .eep_req_i(eep_req_o),
      .eep_valid_o(eep_valid_i), .eep_byte_o(eep_byte_i), .len_i(len), .bad_i(bad),
      .slow_i(slow));

   // ==========================================================
   // Checking
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic test_done;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   function automatic logic [7:0] sts(input logic [4:0] lo);
      return {source_power_pin_i, rx_int_pending_i, 1'b0, lo};
   endfunction : sts

   always @(posedge clk_sys_i)
   begin
      pend <= reg_rd_i;
      cyc++;
      if (cyc == 60000)
      begin
         bad_count++;
         test_done();
      end
   end

   always @(negedge clk_sys_i)
   begin
      if (pend)
         chk("read data", 16'(exp_q.pop_front()), 16'(reg_rdata_o));
      if (sram_we_o === 1'b1)
      begin
         chk("sram addr", 16'(we_cnt[7:0]), 16'(sram_addr_o));
         if (wiping)
            chk("wipe data", 16'h0, 16'(sram_wdata_o));
         else if (we_cnt != 255)
            chk("sram data", 16'((we_cnt * 37 + 5) % 256), 16'(sram_wdata_o));
         we_cnt++;
      end
   end

   // ==========================================================
   // Register port and sequences
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_sys_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      exp_q.push_back(e);
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
   endtask : rd

   task automatic power_up(input logic s, input logic b);
      @(negedge clk_sys_i);
      rst_n_i = 1'b0;
      mode_strap0_i = s;
      bad = b;
      slow = s;
      len = 9'h080;
      st_lo = 5'h03;
      source_power_pin_i = 1'($random(seed));
      rx_int_pending_i = 1'($random(seed));
      repeat (20) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
   endtask : power_up

   task automatic boot(input logic [4:0] lo);
      // Let the sequencer leave its boot state before waiting for the stream to end
      repeat (2) @(negedge clk_sys_i);
      for (int i = 0; i < 2000 && eep_req_o !== 1'b0; i++)
         @(negedge clk_sys_i);
      st_lo = lo;
      rd(8'h50, sts(st_lo));
      init_ack_i = 1'b1;
      @(negedge clk_sys_i);
      init_ack_i = 1'b0;
      st_lo[4] = 1'b1;
      rd(8'h50, sts(st_lo));
   endtask : boot

   task automatic load(input logic [7:0] c, input logic b, input logic r, input logic [4:0] lo);
      wiping = c[2];
      bad = b;
      eep_remote_i = r;
      len = 9'h100;
      we_cnt = 0;
      wr(8'h4F, c);
      for (int i = 0; i < 3000 && we_cnt < 256; i++)
         @(negedge clk_sys_i);
      repeat (3) @(negedge clk_sys_i);
      chk("sram writes", 16'd256, 16'(we_cnt));
      rd(8'h4F, {7'h00, mode_strap0_i});
      st_lo = lo;
      if (!wiping)
         rd(8'h50, sts(st_lo));
   endtask : load

   task automatic cec(input logic [7:0] c, input int n, input int lo, input int hi);
      int e;
      logic p;
      e = 0;
      wr(8'h4F, c);
      p = cec_clk_o;
      repeat (n)
      begin
         @(negedge clk_sys_i);
         if (cec_clk_o === 1'b1 && p === 1'b0)
            e++;
         p = cec_clk_o;
      end
      chk("cec edges", 16'h1, 16'(lo <= e && e <= hi));
   endtask : cec

   task automatic sweep;
      logic [7:0] wv[7];
      @(negedge clk_sys_i);
      source_power_pin_i = 1'($random(seed));
      rx_int_pending_i = 1'($random(seed));
      for (int k = 0; k < 7; k++)
      begin
         wv[k] = 8'($random(seed)) & (k == 2 ? 8'hF9 : 8'hFF);
         wr(sw_a[k], wv[k]);
         rd(sw_a[k], k == 3 ? sts(st_lo) : wv[k] & sw_m[k]);
      end
      for (int rw = 0; rw < 2; rw++)
      begin
         ddc_addr_byte_i = {wv[4][7:1], 1'(rw)};
         #1;
         chk("hit", 16'h1, 16'(ddc_addr_hit_o));
         chk("write ok", 16'(rw == 0 && !wv[4][0]), 16'(ddc_write_ok_o));
         ddc_addr_byte_i = {~wv[4][7:1], 1'(rw)};
         #1;
         chk("miss", 16'h0, 16'(ddc_addr_hit_o));
      end
      chk("hold", 16'({wv[5][6:4], 2'b00}), 16'(ddc_hold_cyc_o));
      chk("filter", 16'(wv[5][3:0] * 5 / 10), 16'(ddc_filter_cyc_o));
      chk("delay", 16'(24 + 4 * wv[6][1:0]), 16'(ddc_delay_cyc_o));
   endtask : sweep

   initial
   begin
      logic [15:0] d;
      seed = 82621;
      // Access block strapped on
      power_up(1'b1, 1'b0);
      foreach (sw_a[k])
         rd(sw_a[k], k == 2 ? 8'h01 : k == 3 ? sts(5'h03) : k == 4 ? 8'hA0 :
            k == 5 ? 8'h1E : 8'h00);
      rd(8'h54, 8'h00);
      ddc_addr_byte_i = 8'hA0;
      #1;
      chk("block", 16'h1, 16'(ddc_block_o));
      chk("blocked hit", 16'h0, 16'(ddc_addr_hit_o));
      chk("hold", 16'd4, 16'(ddc_hold_cyc_o));
      chk("filter", 16'd7, 16'(ddc_filter_cyc_o));
      chk("delay", 16'd24, 16'(ddc_delay_cyc_o));
      boot(5'h07);
      load(8'h02, 1'b0, 1'b1, 5'h1F);
      load(8'h06, 1'b0, 1'b0, 5'h1F);
      cec(8'h08, 15000, 4, 6);
      cec(8'h18, 15000, 4, 6);
      cec(8'h10, 4000, 0, 0);
      // Access block off, faulty configuration image
      power_up(1'b0, 1'b1);
      boot(5'h05);
      repeat (8)
         sweep();
      @(negedge clk_sys_i);
      d = 16'($random(seed));
      apb_rd_data_i = d;
      apb_rd_done_i = 1'b1;
      @(negedge clk_sys_i);
      apb_rd_done_i = 1'b0;
      chk("indirect", d, indirect_data_o);
      rd(8'h4D, d[7:0]);
      rd(8'h4E, d[15:8]);
      load(8'h02, 1'b1, 1'b0, 5'h14);
      repeat (4) @(negedge clk_sys_i);
      test_done();
   end
endmodule : bridge_edid_control_status_regs_tb
